// [crc_byte_step.sv]
// One byte step of the MSB-first checksum shift for both polynomials.
// Assumes a pure combinational use by the checksum generator.
`timescale 1ns/1ps
`include "crc_io_map.svh"
module crc_byte_step (
    input wire logic [31:0] crc_i, // Current checksum.
    input wire logic [7:0] data_i, // Byte to fold in.
    input wire logic wide_i, // High for the 32-bit polynomial.
    output logic [31:0] crc_o // Checksum after the byte.
);
    // The 32-bit path works on the bit-reversed byte so that the final
    // reversed and complemented read gives the usual reflected result.
    // polynomial step
    always_comb begin
        logic [31:0] c;
        logic [7:0] d;
        c = crc_i;
        d = data_i;
        for (int i = 0; i < 8; i++) begin
            if (wide_i) begin
                if (c[31] ^ d[i]) begin
                    c = {c[30:0], 1'b0} ^ `POLY32;
                end else begin
                    c = {c[30:0], 1'b0};
                end
            end else begin
                if (c[15] ^ d[7-i]) begin
                    c = {16'h0000, c[14:0], 1'b0} ^ {16'h0000, `POLY16};
                end else begin
                    c = {16'h0000, c[14:0], 1'b0};
                end
            end
        end
        crc_o = c;
    end
endmodule

// [crc_feed_model.sv]
// Behavioural DMA channels and flash controller that feed the generator.
// Assumes the bench calls send from its own process, off the clock edge.
`timescale 1ns/1ps
module crc_feed_model (
    input wire logic core_clk_i, // Peripheral clock.
    output logic [3:0] dma_valid_o, // Per-channel byte valid.
    output logic [7:0] dma_data_o, // Byte on the DMA path.
    output logic [3:0] dma_done_o, // Per-channel transfer end.
    output logic flash_valid_o, // Flash byte valid.
    output logic [7:0] flash_data_o, // Byte read from flash.
    output logic flash_done_o // Flash range finished.
);
    initial begin
        {flash_valid_o, dma_valid_o} = 5'h00;
        {flash_done_o, dma_done_o} = 5'h00;
        dma_data_o = 8'hC3;
        flash_data_o = 8'h3C;
    end
    // Channel 4 is flash; gap idle cycles follow each byte, 0 streams.
    task automatic send(input int chan, input int gap,
                        input logic [7:0] b [$]);
        @(posedge core_clk_i);
        foreach (b[k]) begin
            {flash_valid_o, dma_valid_o} <= 5'(1 << chan);
            dma_data_o <= b[k];
            flash_data_o <= b[k];
            @(posedge core_clk_i);
            if (gap > 0) begin
                {flash_valid_o, dma_valid_o} <= 5'h00;
                // During a gap the released lanes show the inverse, not the stale byte.
                dma_data_o <= ~b[k];
                flash_data_o <= ~b[k];
                repeat (gap) @(posedge core_clk_i);
            end
        end
        {flash_valid_o, dma_valid_o} <= 5'h00;
        dma_data_o <= ~dma_data_o;
        {flash_done_o, dma_done_o} <= 5'(1 << chan);
        @(posedge core_clk_i);
        {flash_done_o, dma_done_o} <= 5'h00;
    endtask
endmodule

// [crc_generator_io_regs.sv]
// Byte-wide checksum generator with its control, status, byte input and
// result registers, fed by the CPU, four DMA channels or flash.
// Assumes a single-cycle register port on the peripheral clock; the DMA
// and flash controllers are logic on that same clock.
//
// Contract
// - CPU source folds every written input byte, one per cycle.
// - Software ends CPU run by writing one to busy; device clears it.
// - Clear field reads zero; clear happens one cycle after upper bit written.
// - Clear codes: 00 none, 01 reserved, 10 zeros, 11 ones.
// - Bit 5 selects 32-bit polynomial; ignored while busy.
// - Source codes: disable, CPU, flash, reserved, DMA 0 to 3, reserved.
// - Selected source stays locked until completion or clear.
// - Zero flag set when checksum is zero at completion.
// - Zero flag clears when a new source is selected.
// - CRC-32 residue over appended checksum gives magic or zero.
// - Busy reads one from selection while source uses generator.
// - DMA source: busy clears when channel completes or aborts.
// - Flash source: busy clears when range calculation finishes.
// - Updated checksum ready one cycle after input byte write.
// - Result byte writes take effect only while disabled.
// - Flash source: result reads zero until busy clears.
// - CRC-32 with busy clear reads reversed, complemented result.
// - CRC-16 or busy reads raw checksum.
// - Checksum is zero after reset.
// - Result bytes 2 and 3 carry bits only in 32-bit mode.
// - Polynomials are 0x1021 and 0x04C11DB7.
// - Flash source always uses the 32-bit polynomial.
// - Input consumed strictly one byte at a time.
`timescale 1ns/1ps
`include "crc_io_map.svh"
module crc_generator_io_regs
    import crc_io_pkg::*;
(
    input wire logic core_clk_i, // Peripheral clock, 10 MHz.
    input wire logic rst_b_i, // Asynchronous reset, active low.
    input wire logic [2:0] reg_addr_i, // Register offset.
    input wire logic reg_wr_i, // Write strobe, one cycle.
    input wire logic [7:0] reg_wdata_i, // Write data.
    input wire logic reg_rd_i, // Read strobe, one cycle.
    output logic [7:0] reg_rdata_o, // Read data, one cycle after strobe.
    input wire logic [3:0] dma_valid_i, // DMA channel byte valid.
    input wire logic [7:0] dma_data_i, // Byte passing through DMA.
    input wire logic [3:0] dma_done_i, // DMA channel complete or abort.
    input wire logic flash_valid_i, // Flash controller byte valid.
    input wire logic [7:0] flash_data_i, // Byte read from flash.
    input wire logic flash_done_i, // Flash range calculation finished.
    output logic busy_o, // Busy flag.
    output logic zero_o // Zero residue flag.
);
    logic [3:0] source_reg;
    logic [3:0] source_next;
    logic wide_reg;
    logic wide_next;
    logic busy_reg;
    logic busy_next;
    logic zero_reg;
    logic zero_next;
    logic [1:0] clear_reg;
    logic [1:0] clear_next;
    logic [31:0] crc_reg;
    logic [31:0] crc_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic [31:0] step_out;
    logic [31:0] crc_rev;

    wire wr_ctrl = reg_wr_i && (reg_addr_i == `CRC_CONTROL_OFS);
    wire wr_stat = reg_wr_i && (reg_addr_i == `CRC_STATUS_OFS);
    wire wr_byte = reg_wr_i && (reg_addr_i == `BYTE_INPUT_OFS);
    wire wr_res = reg_wr_i && (reg_addr_i[2] == 1'b1);
    wire [1:0] res_idx = reg_addr_i[1:0];
    wire [3:0] new_src = reg_wdata_i[3:0];
    wire src_cpu = (source_reg == SRC_CPU);
    wire src_flash = (source_reg == SRC_FLASH);
    wire src_dma = (source_reg[3:2] == 2'b01);
    wire src_valid = (new_src == SRC_CPU) || (new_src == SRC_FLASH) ||
                     (new_src[3:2] == 2'b01);
    wire disabled = (source_reg == SRC_DISABLE);
    wire wide_eff = wide_reg || src_flash;
    wire src_load = wr_ctrl && !busy_reg &&
                    (src_valid || new_src == SRC_DISABLE);
    // one byte per cycle from the selected source only
    wire cpu_take = busy_reg && src_cpu && wr_byte;
    wire dma_take = busy_reg && src_dma && dma_valid_i[source_reg[1:0]];
    wire flash_take = busy_reg && src_flash && flash_valid_i;
    wire take = cpu_take || dma_take || flash_take;
    wire [7:0] in_byte = cpu_take ? reg_wdata_i :
                         (dma_take ? dma_data_i : flash_data_i);
    wire done = busy_reg && ((src_cpu && wr_stat &&
                reg_wdata_i[`STAT_BUSY_BIT]) ||
                (src_dma && dma_done_i[source_reg[1:0]]) ||
                (src_flash && flash_done_i));
    // narrow mode keeps the upper bytes at zero
    wire [31:0] crc_masked = wide_eff ? crc_reg : {16'h0000, crc_reg[15:0]};
    assign crc_rev = {<<{crc_reg}};
    wire [31:0] crc_view = (wide_eff && !busy_reg) ? ~crc_rev :
                           crc_masked;
    wire [31:0] crc_read = (src_flash && busy_reg) ? 32'h0000_0000 : crc_view;

    crc_byte_step u_step (
        .crc_i(crc_reg),
        .data_i(in_byte),
        .wide_i(wide_eff),
        .crc_o(step_out)
    );

    always_comb begin
        source_next = source_reg;
        wide_next = wide_reg;
        busy_next = busy_reg;
        zero_next = zero_reg;
        clear_next = CLR_NONE;
        crc_next = crc_reg;
        if (wr_ctrl && !busy_reg) begin
            wide_next = reg_wdata_i[`CTRL_WIDE_BIT];
        end
        // clear request latched, applied next cycle
        if (wr_ctrl && reg_wdata_i[`CTRL_CLEAR_HI_BIT]) begin
            clear_next = reg_wdata_i[`CTRL_CLEAR_HI_BIT:`CTRL_CLEAR_LO_BIT];
        end
        if (src_load) begin
            source_next = new_src;
            busy_next = (new_src != SRC_DISABLE);
            // zero flag cleared on new source
            zero_next = 1'b0;
        end
        // checksum updates the cycle after the byte
        if (take) begin
            crc_next = step_out;
        end
        if (done) begin
            busy_next = 1'b0;
            // zero at completion, on the raw register
            zero_next = (crc_masked == 32'h0000_0000);
        end
        if (wr_res && disabled) begin
            crc_next[res_idx*8 +: 8] = reg_wdata_i;
        end
        // A clear wins over a same-cycle byte or result write, so every run
        // starts from the seed that software asked for.
        // clear codes; a clear also unlocks the source
        if (clear_reg == CLR_ZEROS || clear_reg == CLR_ONES) begin
            crc_next = (clear_reg == CLR_ONES) ? `RESULT_ONES_VAL :
                       `RESULT_RESET_VAL;
            busy_next = 1'b0;
            source_next = SRC_DISABLE;
        end
    end

    always_comb begin
        rdata_next = 8'h00;
        case (reg_addr_i)
            `CRC_CONTROL_OFS: rdata_next = {2'b00, wide_reg, 1'b0,
                                            source_reg};
            `CRC_STATUS_OFS: rdata_next = {6'h00, zero_reg, busy_reg};
            `RESULT_BYTE0_OFS: rdata_next = crc_read[7:0];
            `RESULT_BYTE1_OFS: rdata_next = crc_read[15:8];
            `RESULT_BYTE2_OFS: rdata_next = crc_read[23:16];
            `RESULT_BYTE3_OFS: rdata_next = crc_read[31:24];
            default: rdata_next = 8'h00;
        endcase
        if (!reg_rd_i) begin
            rdata_next = 8'h00;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            source_reg <= 4'h0;
            wide_reg <= 1'b0;
            busy_reg <= 1'b0;
            zero_reg <= 1'b0;
            clear_reg <= 2'h0;
            crc_reg <= `RESULT_RESET_VAL;
            rdata_reg <= 8'h00;
        end else begin
            source_reg <= source_next;
            wide_reg <= wide_next;
            busy_reg <= busy_next;
            zero_reg <= zero_next;
            clear_reg <= clear_next;
            crc_reg <= crc_next;
            rdata_reg <= rdata_next;
        end
    end

    assign reg_rdata_o = rdata_reg;
    assign busy_o = busy_reg;
    assign zero_o = zero_reg;

    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!rst_b_i);

    clear_one_cycle_a: assert property (
        wr_ctrl && reg_wdata_i[7:6] == 2'b11 |=> ##1 crc_reg == 32'hFFFF_FFFF)
        else $error("clear to ones not applied after one cycle");
    clear_zero_a: assert property (
        wr_ctrl && reg_wdata_i[7:6] == 2'b10 |=> ##1 crc_reg == 32'h0)
        else $error("clear to zeros not applied");
    wide_lock_a: assert property (
        busy_reg |=> $stable(wide_reg))
        else $error("wide bit changed while busy");
    source_lock_a: assert property (
        busy_reg && clear_reg[1] == 1'b0 |=> $stable(source_reg) || !busy_reg)
        else $error("source changed while locked");
    zero_new_src_a: assert property (
        src_load && !done |=> !zero_reg)
        else $error("zero flag not cleared on new source");
    cpu_end_a: assert property (
        busy_reg && src_cpu && wr_stat && reg_wdata_i[0] && !clear_reg[1]
        && !src_load |=> !busy_reg)
        else $error("cpu end did not clear busy");
    dma_end_a: assert property (
        busy_reg && src_dma && dma_done_i[source_reg[1:0]] |=> !busy_reg)
        else $error("dma completion did not clear busy");
    byte_fold_a: assert property (
        cpu_take && clear_reg == 2'b00 && !(wr_res && disabled)
        |=> crc_reg == $past(step_out))
        else $error("checksum not updated after byte");
    ignore_byte_a: assert property (
        wr_byte && !src_cpu && !dma_take && !flash_take
        && clear_reg == 2'b00 && !(wr_res && disabled) |=> $stable(crc_reg))
        else $error("byte folded from wrong source");
    flash_hide_a: assert property (
        reg_rd_i && reg_addr_i[2] && src_flash && busy_reg
        |=> reg_rdata_o == 8'h00)
        else $error("flash result visible while busy");

    wide_write_a: assert property (
        wr_ctrl && !busy_reg |=> wide_reg == $past(reg_wdata_i[5]))
        else $error("wide bit write not taken while idle");
    // Completion and selection effects on the status flags.
    zero_at_done_a: assert property (
        done && crc_masked == 32'h0000_0000 |=> zero_reg)
        else $error("zero flag not set at completion");
    busy_select_a: assert property (
        src_load && new_src != SRC_DISABLE && !clear_reg[1] |=> busy_reg)
        else $error("busy not set on source selection");
    flash_end_a: assert property (
        busy_reg && src_flash && flash_done_i |=> !busy_reg)
        else $error("flash completion did not clear busy");
    status_read_a: assert property (
        reg_rd_i && reg_addr_i == `CRC_STATUS_OFS
        |=> reg_rdata_o[0] == $past(busy_reg))
        else $error("busy flag read back wrong");
    // The checksum only moves through a byte, a clear or a disabled write.
    result_lock_a: assert property (
        wr_res && !disabled && !take && !clear_reg[1] |=> $stable(crc_reg))
        else $error("result write landed while enabled");
    other_lane_a: assert property (
        busy_reg && src_dma && !dma_take && clear_reg == 2'b00
        |=> $stable(crc_reg))
        else $error("checksum moved without selected channel byte");
    dma_fold_a: assert property (
        dma_take && clear_reg == 2'b00 |=> crc_reg == $past(step_out))
        else $error("dma byte not folded");
    flash_fold_a: assert property (
        flash_take && clear_reg == 2'b00 |=> crc_reg == $past(step_out))
        else $error("flash byte not folded");
    reserved_src_a: assert property (
        wr_ctrl && (reg_wdata_i[3:0] == 4'h3 || reg_wdata_i[3]) &&
        !clear_reg[1] |=> $stable(source_reg))
        else $error("reserved source code accepted");
    // Read view checks sample the register one cycle before the data shows.
    clear_read_a: assert property (
        reg_rd_i && reg_addr_i == `CRC_CONTROL_OFS
        |=> reg_rdata_o[7:6] == 2'b00)
        else $error("clear field read back nonzero");
    wide_read_a: assert property (
        reg_rd_i && reg_addr_i == `RESULT_BYTE0_OFS &&
        wide_eff && !busy_reg
        |=> reg_rdata_o[0] == !$past(crc_reg[31]) &&
        reg_rdata_o[7] == !$past(crc_reg[24]))
        else $error("wide result not reversed and complemented");
    raw_read_a: assert property (
        reg_rd_i && reg_addr_i == `RESULT_BYTE1_OFS && busy_reg &&
        !src_flash |=> reg_rdata_o == $past(crc_reg[15:8]))
        else $error("raw result read back wrong");
    narrow_upper_a: assert property (
        reg_rd_i && reg_addr_i == `RESULT_BYTE3_OFS && !wide_eff
        |=> reg_rdata_o == 8'h00)
        else $error("upper result byte nonzero in narrow mode");

    cover_cpu_run_c: cover property (cpu_take ##1 cpu_take ##[1:5] done);
    cover_dma_run_c: cover property (dma_take ##[1:10] done);
    cover_flash_run_c: cover property (flash_take ##[1:10] done && zero_next);
    cover_clear_c: cover property (clear_reg == 2'b11);
    cover_residue_c: cover property (done && crc_masked == 32'h0000_0000);
endmodule

// [crc_io_map.svh]
// Register offsets, field positions, reset values and polynomials of the
// byte-wide checksum generator.
// Assumes inclusion by the design files and the bench by bare name.
`ifndef CRC_IO_MAP_SVH
`define CRC_IO_MAP_SVH
`define CRC_CONTROL_OFS 3'h0
`define CRC_STATUS_OFS 3'h1
`define BYTE_INPUT_OFS 3'h3
`define RESULT_BYTE0_OFS 3'h4
`define RESULT_BYTE1_OFS 3'h5
`define RESULT_BYTE2_OFS 3'h6
`define RESULT_BYTE3_OFS 3'h7
`define CTRL_CLEAR_HI_BIT 7
`define CTRL_CLEAR_LO_BIT 6
`define CTRL_WIDE_BIT 5
`define STAT_ZERO_BIT 1
`define STAT_BUSY_BIT 0
`define CTRL_RESET_VAL 8'h00
`define CTRL_WRITE_MASK 8'h2F
`define POLY16 16'h1021
`define POLY32 32'h04C11DB7
`define RESULT_RESET_VAL 32'h0000_0000
`define RESULT_ONES_VAL 32'hFFFF_FFFF
`define WIDE_POLY_SELECT_MAGIC_RESIDUE 32'h2144_DF1C
`endif

// [crc_io_pkg.sv]
// Types shared by the checksum generator files.
// Assumes the map header sits in the same folder.
package crc_io_pkg;
    typedef enum logic [3:0] {
        SRC_DISABLE = 4'h0,
        SRC_CPU = 4'h1,
        SRC_FLASH = 4'h2,
        SRC_DMA0 = 4'h4,
        SRC_DMA1 = 4'h5,
        SRC_DMA2 = 4'h6,
        SRC_DMA3 = 4'h7
    } source_type;
    typedef enum logic [1:0] {
        CLR_NONE = 2'h0,
        CLR_RSVD = 2'h1,
        CLR_ZEROS = 2'h2,
        CLR_ONES = 2'h3
    } clear_type;
endpackage

// [tb_top.sv]
// Self-checking bench for the checksum generator and its feed model.
// Assumes the map header and the package are compiled first.
`timescale 1ns/1ps
`include "crc_io_map.svh"
module tb_top;
    typedef logic [7:0] bytes_type [$];
    localparam logic [31:0] poly32 = `POLY32;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00;
    logic [7:0] rdata, ddata, fdata;
    logic [3:0] dvalid, ddone;
    logic fvalid, fdone, busy, zero;
    logic [31:0] e;
    logic [1:0] codes [4] = '{2'h2, 2'h3, 2'h1, 2'h0};
    int errors = 0;
    int checks_done = 0;
    bytes_type q;
    bytes_type msg = '{8'h31, 8'h32, 8'h33, 8'h34, 8'h35, 8'h36, 8'h37};
    always #50 clk = ~clk;
    crc_generator_io_regs crc_generator_io_regs_i (
        .core_clk_i(clk), .rst_b_i(rst_b), .reg_addr_i(addr),
        .reg_wr_i(wr), .reg_wdata_i(wdata), .reg_rd_i(rd),
        .reg_rdata_o(rdata), .dma_valid_i(dvalid), .dma_data_i(ddata),
        .dma_done_i(ddone), .flash_valid_i(fvalid), .flash_data_i(fdata),
        .flash_done_i(fdone), .busy_o(busy), .zero_o(zero));
    crc_feed_model crc_feed_model_i (
        .core_clk_i(clk), .dma_valid_o(dvalid), .dma_data_o(ddata),
        .dma_done_o(ddone), .flash_valid_o(fvalid), .flash_data_o(fdata),
        .flash_done_o(fdone));
    function automatic logic [15:0] c16(input bytes_type b);
        logic [15:0] c;
        c = 16'h0000;
        foreach (b[k]) begin
            c = c ^ {b[k], 8'h00};
            for (int i = 0; i < 8; i++)
                c = {c[14:0], 1'b0} ^ (c[15] ? `POLY16 : 16'h0000);
        end
        return c;
    endfunction
    // Reflected register seeded with ones; the wide mode reads back its complement.
    function automatic logic [31:0] c32(input bytes_type b);
        logic [31:0] c, rp;
        for (int i = 0; i < 32; i++) rp[i] = poly32[31 - i];
        c = 32'hFFFF_FFFF;
        foreach (b[k]) begin
            c = c ^ {24'h000000, b[k]};
            for (int i = 0; i < 8; i++) c = (c >> 1) ^ (c[0] ? rp : 32'h0);
        end
        return c;
    endfunction
    task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        d = rdata;
    endtask
    task automatic wr_burst(input bytes_type b);
        @(posedge clk);
        foreach (b[k]) begin
            addr <= `BYTE_INPUT_OFS;
            wdata <= b[k];
            wr <= 1'b1;
            @(posedge clk);
        end
        wr <= 1'b0;
    endtask
    // The clear lands a cycle later than other writes, so wait one more.
    task automatic clr(input logic [1:0] code);
        wr_reg(`CRC_CONTROL_OFS, {code, 6'h00});
        @(posedge clk);
    endtask
    task automatic cmp(input string what, input logic [31:0] x,
                       input logic [31:0] s);
        checks_done++;
        if (s !== x) begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, x, s);
        end
    endtask
    task automatic chk_reg(input logic [2:0] a, input logic [7:0] x);
        logic [7:0] d;
        rd_reg(a, d);
        cmp($sformatf("register %0d", a), {24'h0, x}, {24'h0, d});
    endtask
    task automatic chk_sum(input logic [31:0] x);
        logic [7:0] b [4];
        for (int k = 0; k < 4; k++) rd_reg(3'(4 + k), b[k]);
        cmp("checksum", x, {b[3], b[2], b[1], b[0]});
    endtask
    task automatic chk_flags(input logic xb, input logic xz);
        @(posedge clk);
        @(negedge clk);
        cmp("busy and zero", {30'h0, xb, xz}, {30'h0, busy, zero});
    endtask
    task automatic print_verdict();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        #(4000 * 100);
        errors++;
        $display("watchdog expired");
        print_verdict();
    end
    initial begin
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        for (int a = 0; a < 8; a++) chk_reg(3'(a), 8'h00);
        $display("test reset done");
        wr_reg(`CRC_CONTROL_OFS, 8'h01);
        chk_flags(1'b1, 1'b0);
        wr_reg(`CRC_CONTROL_OFS, 8'h22);
        chk_reg(`CRC_CONTROL_OFS, 8'h01);
        wr_reg(`RESULT_BYTE0_OFS, 8'h5A);
        wr_burst(msg);
        chk_sum({16'h0000, c16(msg)});
        wr_reg(`CRC_STATUS_OFS, 8'h01);
        chk_flags(1'b0, 1'b0);
        chk_sum({16'h0000, c16(msg)});
        wr_reg(`CRC_CONTROL_OFS, 8'h00);
        wr_reg(`RESULT_BYTE0_OFS, 8'h5A);
        chk_reg(`RESULT_BYTE0_OFS, 8'h5A);
        wr_reg(`CRC_CONTROL_OFS, 8'h03);
        wr_reg(`CRC_CONTROL_OFS, 8'h08);
        chk_reg(`CRC_CONTROL_OFS, 8'h00);
        $display("test cpu done");
        foreach (codes[i]) begin
            clr(codes[i]);
            chk_sum(i == 0 ? 32'h0000_0000 : 32'h0000_FFFF);
        end
        chk_reg(`CRC_CONTROL_OFS, 8'h00);
        $display("test clear done");
        for (int ch = 0; ch < 4; ch++) begin
            clr(2'h3);
            wr_reg(`CRC_CONTROL_OFS, {4'h2, 4'(4 + ch)});
            chk_flags(1'b1, 1'b0);
            chk_sum(32'hFFFF_FFFF);
            crc_feed_model_i.send(ch, ch, msg);
            chk_flags(1'b0, 1'b0);
            chk_sum(~c32(msg));
        end
        $display("test dma done");
        clr(2'h3);
        wr_reg(`CRC_CONTROL_OFS, 8'h21);
        q = msg;
        e = ~c32(msg);
        for (int i = 0; i < 4; i++) q.push_back(e[8 * i +: 8]);
        wr_burst(q);
        wr_reg(`CRC_STATUS_OFS, 8'h01);
        chk_sum(`WIDE_POLY_SELECT_MAGIC_RESIDUE);
        $display("test residue done");
        clr(2'h3);
        wr_reg(`CRC_CONTROL_OFS, 8'h02);
        chk_sum(32'h0000_0000);
        wr_reg(`BYTE_INPUT_OFS, 8'h55);
        q = msg;
        e = c32(msg);
        for (int i = 0; i < 4; i++) q.push_back(e[8 * i +: 8]);
        crc_feed_model_i.send(4, 0, q);
        chk_flags(1'b0, 1'b1);
        wr_reg(`CRC_CONTROL_OFS, 8'h01);
        chk_flags(1'b1, 1'b0);
        $display("test flash done");
        print_verdict();
    end
endmodule
